// File: rtl/mbi_top.sv
// Mailbox interrupt generator for the PCI side and the Add-On side.
// Assumes mailbox access strobes and register writes come from logic on clk.
//
// Contract
// - Mailbox interrupts toward both PCI and Add-On
// - Four conditions, each with own enable
// - One selectable byte per direction triggers
// - PCI outgoing: Add-On read raises INTA
// - PCI incoming: Add-On write raises INTA
// - Add-On outgoing: PCI read raises IRQ
// - Add-On incoming: PCI write raises IRQ
// - Both directions programmable in one write
// - Pending flags at bits 16 and 17
// - Write one clears; line drops when none
`timescale 1ns/100ps
module mbi_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pci_ctl_wr,
    input wire logic [31:0] pci_ctl_wdata,
    output logic [31:0] pci_ctl_rdata,
    input wire logic addon_ctl_wr,
    input wire logic [31:0] addon_ctl_wdata,
    output logic [31:0] addon_ctl_rdata,
    input wire logic pci_mb_wr,
    input wire logic pci_mb_rd,
    input wire logic [1:0] pci_mb_idx,
    input wire logic [3:0] pci_mb_be,
    input wire logic addon_mb_wr,
    input wire logic addon_mb_rd,
    input wire logic [1:0] addon_mb_idx,
    input wire logic [3:0] addon_mb_be,
    output logic inta_n,
    output logic addon_irq_n
);

    // ========================================================================
    // Elaboration checks
    // ========================================================================
    // The register image must hold both pending flags above the config fields
    if (mbi_pkg::REG_W != $bits(pci_ctl_rdata)
        || mbi_pkg::IN_PEND_BIT >= mbi_pkg::REG_W) begin : g_bad_width
        $error("register layout does not fit the control image");
    end
    // A byte selector must address exactly the lanes of one mailbox
    if ((1 << mbi_pkg::SEL_W) != mbi_pkg::BE_W
        || $bits(pci_mb_be) != mbi_pkg::BE_W) begin : g_bad_lanes
        $error("byte selector does not match the lane count");
    end
    // Pending flags are status only and must never be stored as configuration
    if (mbi_pkg::CFG_MASK[mbi_pkg::OUT_PEND_BIT]
        || mbi_pkg::CFG_MASK[mbi_pkg::IN_PEND_BIT]) begin : g_bad_mask
        $error("configuration mask overlaps the pending flags");
    end

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [31:0] pci_cfg;
        logic [31:0] addon_cfg;
        logic pci_out_pend;
        logic pci_in_pend;
        logic addon_out_pend;
        logic addon_in_pend;
        logic [31:0] pci_rdata;
        logic [31:0] addon_rdata;
        logic inta_n;
        logic irq_n;
    } mbi_state_t;

    mbi_state_t st;
    mbi_state_t next_st;

    logic hit_pci_out;
    logic hit_pci_in;
    logic hit_addon_out;
    logic hit_addon_in;

    // ========================================================================
    // Access events
    // ========================================================================
    mbi_acc_if pci_wr_acc ();
    mbi_acc_if pci_rd_acc ();
    mbi_acc_if addon_wr_acc ();
    mbi_acc_if addon_rd_acc ();

    // PCI side accesses
    assign pci_wr_acc.stb = pci_mb_wr;
    assign pci_wr_acc.idx = pci_mb_idx;
    assign pci_wr_acc.be = pci_mb_be;
    assign pci_rd_acc.stb = pci_mb_rd;
    assign pci_rd_acc.idx = pci_mb_idx;
    assign pci_rd_acc.be = pci_mb_be;

    // Add-On side accesses
    assign addon_wr_acc.stb = addon_mb_wr;
    assign addon_wr_acc.idx = addon_mb_idx;
    assign addon_wr_acc.be = addon_mb_be;
    assign addon_rd_acc.stb = addon_mb_rd;
    assign addon_rd_acc.idx = addon_mb_idx;
    assign addon_rd_acc.be = addon_mb_be;

    // ========================================================================
    // Byte matchers, one per condition
    // ========================================================================
    // PCI outgoing byte read by the Add-On side
    mbi_byte_match u_pci_out (
        .acc(addon_rd_acc),
        .en(st.pci_cfg[mbi_pkg::LO_EN_BIT]),
        .mb_sel(st.pci_cfg[mbi_pkg::LO_MB_LSB +: mbi_pkg::SEL_W]),
        .by_sel(st.pci_cfg[mbi_pkg::LO_BY_LSB +: mbi_pkg::SEL_W]),
        .hit(hit_pci_out)
    );

    // PCI incoming byte written by the Add-On side
    mbi_byte_match u_pci_in (
        .acc(addon_wr_acc),
        .en(st.pci_cfg[mbi_pkg::HI_EN_BIT]),
        .mb_sel(st.pci_cfg[mbi_pkg::HI_MB_LSB +: mbi_pkg::SEL_W]),
        .by_sel(st.pci_cfg[mbi_pkg::HI_BY_LSB +: mbi_pkg::SEL_W]),
        .hit(hit_pci_in)
    );

    // Add-On outgoing byte read by the PCI side
    mbi_byte_match u_addon_out (
        .acc(pci_rd_acc),
        .en(st.addon_cfg[mbi_pkg::HI_EN_BIT]),
        .mb_sel(st.addon_cfg[mbi_pkg::HI_MB_LSB +: mbi_pkg::SEL_W]),
        .by_sel(st.addon_cfg[mbi_pkg::HI_BY_LSB +: mbi_pkg::SEL_W]),
        .hit(hit_addon_out)
    );

    // Add-On incoming byte written by the PCI side
    mbi_byte_match u_addon_in (
        .acc(pci_wr_acc),
        .en(st.addon_cfg[mbi_pkg::LO_EN_BIT]),
        .mb_sel(st.addon_cfg[mbi_pkg::LO_MB_LSB +: mbi_pkg::SEL_W]),
        .by_sel(st.addon_cfg[mbi_pkg::LO_BY_LSB +: mbi_pkg::SEL_W]),
        .hit(hit_addon_in)
    );

    // ========================================================================
    // Next state
    // ========================================================================
    // Register writes, write-one clears, event sets (set beats clear)
    always_comb begin
        next_st = st;
        // PCI side register: both directions in one write
        if (pci_ctl_wr) begin
            next_st.pci_cfg = pci_ctl_wdata & mbi_pkg::CFG_MASK;
            if (pci_ctl_wdata[mbi_pkg::OUT_PEND_BIT]) begin
                next_st.pci_out_pend = 1'b0;
            end
            if (pci_ctl_wdata[mbi_pkg::IN_PEND_BIT]) begin
                next_st.pci_in_pend = 1'b0;
            end
        end
        // Add-On side register: both directions in one write
        if (addon_ctl_wr) begin
            next_st.addon_cfg = addon_ctl_wdata & mbi_pkg::CFG_MASK;
            if (addon_ctl_wdata[mbi_pkg::OUT_PEND_BIT]) begin
                next_st.addon_out_pend = 1'b0;
            end
            if (addon_ctl_wdata[mbi_pkg::IN_PEND_BIT]) begin
                next_st.addon_in_pend = 1'b0;
            end
        end
        // Events recorded after the clears so a same-cycle event survives
        if (hit_pci_out) begin
            next_st.pci_out_pend = 1'b1;
        end
        if (hit_pci_in) begin
            next_st.pci_in_pend = 1'b1;
        end
        if (hit_addon_out) begin
            next_st.addon_out_pend = 1'b1;
        end
        if (hit_addon_in) begin
            next_st.addon_in_pend = 1'b1;
        end
        // Lines held while any enabled request is pending
        next_st.inta_n = ~((next_st.pci_out_pend & next_st.pci_cfg[mbi_pkg::LO_EN_BIT])
            | (next_st.pci_in_pend & next_st.pci_cfg[mbi_pkg::HI_EN_BIT]));
        next_st.irq_n = ~((next_st.addon_out_pend & next_st.addon_cfg[mbi_pkg::HI_EN_BIT])
            | (next_st.addon_in_pend & next_st.addon_cfg[mbi_pkg::LO_EN_BIT]));
        // Read-back images: configuration plus pending indicators
        next_st.pci_rdata = next_st.pci_cfg;
        next_st.pci_rdata[mbi_pkg::OUT_PEND_BIT] = next_st.pci_out_pend;
        next_st.pci_rdata[mbi_pkg::IN_PEND_BIT] = next_st.pci_in_pend;
        next_st.addon_rdata = next_st.addon_cfg;
        next_st.addon_rdata[mbi_pkg::OUT_PEND_BIT] = next_st.addon_out_pend;
        next_st.addon_rdata[mbi_pkg::IN_PEND_BIT] = next_st.addon_in_pend;
    end

    // ========================================================================
    // State register
    // ========================================================================
    // Synchronous reset: everything disabled, lines released
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st.pci_cfg <= mbi_pkg::REG_RESET;
            st.addon_cfg <= mbi_pkg::REG_RESET;
            st.pci_out_pend <= 1'b0;
            st.pci_in_pend <= 1'b0;
            st.addon_out_pend <= 1'b0;
            st.addon_in_pend <= 1'b0;
            st.pci_rdata <= mbi_pkg::REG_RESET;
            st.addon_rdata <= mbi_pkg::REG_RESET;
            st.inta_n <= 1'b1;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Outputs, straight from the state register
    // ========================================================================
    assign pci_ctl_rdata = st.pci_rdata;
    assign addon_ctl_rdata = st.addon_rdata;
    assign inta_n = st.inta_n;
    assign addon_irq_n = st.irq_n;

endmodule : mbi_top

// File: pkg/mbi_pkg.sv
// Constants for the mailbox interrupt generator: control register field
// positions, masks and widths shared by the top module and the byte matcher.
// Assumes both sides' control registers are 32 bits wide.
package mbi_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int REG_W = 32;
    localparam int SEL_W = 2;   // Mailbox and byte selectors
    localparam int BE_W = 4;    // Byte lanes per mailbox

    // ========================================================================
    // Low field group, bits 4:0 (PCI outgoing, Add-On incoming)
    // ========================================================================
    localparam int LO_EN_BIT = 4;
    localparam int LO_MB_LSB = 2;
    localparam int LO_BY_LSB = 0;

    // ========================================================================
    // High field group, bits 12:8 (PCI incoming, Add-On outgoing)
    // ========================================================================
    localparam int HI_EN_BIT = 12;
    localparam int HI_MB_LSB = 10;
    localparam int HI_BY_LSB = 8;

    // ========================================================================
    // Pending indicators, write one to clear
    // ========================================================================
    localparam int OUT_PEND_BIT = 16;
    localparam int IN_PEND_BIT = 17;

    // Writable configuration bits; all others are kept at zero
    localparam logic [31:0] CFG_MASK = 32'h0000_1f1f;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage : mbi_pkg

// File: pkg/mbi_acc_if.sv
// Carrier for one mailbox access event: strobe, mailbox index and byte lanes.
// Assumes the driver and the receiver share one clock.
`timescale 1ns/100ps
interface mbi_acc_if;
    logic stb;
    logic [mbi_pkg::SEL_W-1:0] idx;
    logic [mbi_pkg::BE_W-1:0] be;

    modport src (output stb, output idx, output be);
    modport dst (input stb, input idx, input be);
endinterface : mbi_acc_if

// File: rtl/mbi_byte_match.sv
// Decides whether one mailbox access touches the selected mailbox byte.
// Assumes the access strobe lasts one cycle per access.
`timescale 1ns/100ps
module mbi_byte_match (
    mbi_acc_if.dst acc,
    input wire logic en,
    input wire logic [mbi_pkg::SEL_W-1:0] mb_sel,
    input wire logic [mbi_pkg::SEL_W-1:0] by_sel,
    output logic hit
);

    // ========================================================================
    // Match
    // ========================================================================
    // Selector codes 00..11 name mailbox 1..4 and byte lane 0..3
    always_comb begin
        hit = en && acc.stb && (acc.idx == mb_sel) && acc.be[by_sel];
    end

endmodule : mbi_byte_match

// File: sim/mbi_far.sv
// Far-side model: PCI host and Add-On logic making control writes and mailbox accesses.
// Assumes the testbench calls its tasks; signals change on falling edges.
`timescale 1ns/100ps
module mbi_far (
    input wire logic clk,
    output logic pci_ctl_wr,
    output logic [31:0] pci_ctl_wdata,
    output logic addon_ctl_wr,
    output logic [31:0] addon_ctl_wdata,
    output logic pci_mb_wr,
    output logic pci_mb_rd,
    output logic [1:0] pci_mb_idx,
    output logic [3:0] pci_mb_be,
    output logic addon_mb_wr,
    output logic addon_mb_rd,
    output logic [1:0] addon_mb_idx,
    output logic [3:0] addon_mb_be
);
    // ====
    // Idle: no strobes
    initial begin
        {pci_ctl_wr, addon_ctl_wr, pci_mb_wr, pci_mb_rd, addon_mb_wr, addon_mb_rd} = 6'h0;
        {pci_ctl_wdata, addon_ctl_wdata} = 64'h0;
        {pci_mb_idx, pci_mb_be, addon_mb_idx, addon_mb_be} = 12'h0;
    end
    // Whole-word control write, s=1 for the Add-On side; idle data scrambled after
    task automatic reg_wr(input logic s, input logic [31:0] d);
        @(negedge clk);
        if (s) {addon_ctl_wr, addon_ctl_wdata} = {1'h1, d};
        else {pci_ctl_wr, pci_ctl_wdata} = {1'h1, d};
        @(negedge clk);
        {pci_ctl_wr, addon_ctl_wr} = 2'h0;
        {pci_ctl_wdata, addon_ctl_wdata} = ~{pci_ctl_wdata, addon_ctl_wdata};
    endtask : reg_wr
    // One mailbox access, s=1 by Add-On, r=1 for a read
    task automatic acc(input logic s, input logic r, input logic [1:0] i, input logic [3:0] b);
        @(negedge clk);
        if (s) {addon_mb_rd, addon_mb_wr, addon_mb_idx, addon_mb_be} = {r, !r, i, b};
        else {pci_mb_rd, pci_mb_wr, pci_mb_idx, pci_mb_be} = {r, !r, i, b};
        @(negedge clk);
        {pci_mb_rd, pci_mb_wr, addon_mb_rd, addon_mb_wr} = 4'h0;
        {pci_mb_idx, pci_mb_be, addon_mb_idx, addon_mb_be} =
            ~{pci_mb_idx, pci_mb_be, addon_mb_idx, addon_mb_be};
    endtask : acc
endmodule : mbi_far

// File: sim/mbi_chk_assertions.sv
// Checker for the mailbox interrupt generator, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/100ps
module mbi_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pci_ctl_wr,
    input wire logic [31:0] pci_ctl_wdata,
    input wire logic [31:0] pci_ctl_rdata,
    input wire logic addon_ctl_wr,
    input wire logic [31:0] addon_ctl_rdata,
    input wire logic pci_mb_wr,
    input wire logic pci_mb_rd,
    input wire logic [1:0] pci_mb_idx,
    input wire logic [3:0] pci_mb_be,
    input wire logic addon_mb_wr,
    input wire logic addon_mb_rd,
    input wire logic [1:0] addon_mb_idx,
    input wire logic [3:0] addon_mb_be,
    input wire logic inta_n,
    input wire logic addon_irq_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ====
    // Matching accesses against the stored selections
    wire [31:0] pr = pci_ctl_rdata;
    wire [31:0] ar = addon_ctl_rdata;
    wire ev_po = addon_mb_rd && addon_mb_idx == pr[3:2] && addon_mb_be[pr[1:0]]
        && pr[4] && !pci_ctl_wr;
    wire ev_pi = addon_mb_wr && addon_mb_idx == pr[11:10] && addon_mb_be[pr[9:8]]
        && pr[12] && !pci_ctl_wr;
    wire ev_ao = pci_mb_rd && pci_mb_idx == ar[11:10] && pci_mb_be[ar[9:8]]
        && ar[12] && !addon_ctl_wr;
    wire ev_ai = pci_mb_wr && pci_mb_idx == ar[3:2] && pci_mb_be[ar[1:0]]
        && ar[4] && !addon_ctl_wr;
    property p_pci_out; ev_po |=> !inta_n && pr[16]; endproperty
    a_pci_out: assert property (p_pci_out) else $error("pci outgoing event missed");
    property p_pci_in; ev_pi |=> !inta_n && pr[17]; endproperty
    a_pci_in: assert property (p_pci_in) else $error("pci incoming event missed");
    property p_add_out; ev_ao |=> !addon_irq_n && ar[16]; endproperty
    a_add_out: assert property (p_add_out) else $error("addon outgoing event missed");
    property p_add_in; ev_ai |=> !addon_irq_n && ar[17]; endproperty
    a_add_in: assert property (p_add_in) else $error("addon incoming event missed");
    property p_pci_line; inta_n == !(pr[16] && pr[4] || pr[17] && pr[12]); endproperty
    a_pci_line: assert property (p_pci_line) else $error("inta_n wrong");
    property p_add_line; addon_irq_n == !(ar[16] && ar[12] || ar[17] && ar[4]); endproperty
    a_add_line: assert property (p_add_line) else $error("addon_irq_n wrong");
    property p_cfg_wr;
        pci_ctl_wr |=> pr[15:0] == ($past(pci_ctl_wdata[15:0]) & 16'h1f1f);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");
    property p_clr; pci_ctl_wr && pci_ctl_wdata[16] && !addon_mb_rd |=> !pr[16]; endproperty
    a_clr: assert property (p_clr) else $error("pending not cleared");
    property p_rsv; (pr & 32'hfffc_e0e0) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    c_pci: cover property (ev_po ##1 !inta_n);
    c_add: cover property (ev_ai);
    c_clr: cover property (pci_ctl_wr && pci_ctl_wdata[16] && !inta_n);
endmodule : mbi_chk
bind mbi_top mbi_chk u_chk (.clk(clk), .resetn(resetn), .pci_ctl_wr(pci_ctl_wr),
    .pci_ctl_wdata(pci_ctl_wdata), .pci_ctl_rdata(pci_ctl_rdata), .addon_ctl_wr(addon_ctl_wr),
    .addon_ctl_rdata(addon_ctl_rdata), .pci_mb_wr(pci_mb_wr), .pci_mb_rd(pci_mb_rd),
    .pci_mb_idx(pci_mb_idx), .pci_mb_be(pci_mb_be), .addon_mb_wr(addon_mb_wr),
    .addon_mb_rd(addon_mb_rd), .addon_mb_idx(addon_mb_idx), .addon_mb_be(addon_mb_be),
    .inta_n(inta_n), .addon_irq_n(addon_irq_n));

// File: sim/testbench.sv
// Self-checking bench for the mailbox interrupt generator.
// Assumes the far-side model drives every design input except clk and resetn.
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    typedef struct {logic [15:0] pc; logic [15:0] ac; logic s; logic r;
        logic [1:0] i; logic [3:0] b; logic [1:0] pp; logic [1:0] ap;} mbi_row_t;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic pci_ctl_wr, addon_ctl_wr, pci_mb_wr, pci_mb_rd, addon_mb_wr, addon_mb_rd;
    logic inta_n, addon_irq_n;
    logic [31:0] pci_ctl_wdata, addon_ctl_wdata, pci_ctl_rdata, addon_ctl_rdata;
    logic [1:0] pci_mb_idx, addon_mb_idx;
    logic [3:0] pci_mb_be, addon_mb_be;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    // Configs, access, expected pending pairs {incoming, outgoing}
    mbi_row_t rows [9] = '{'{16'h0017, 16'h0, 1'h1, 1'h1, 2'h1, 4'h8, 2'h1, 2'h0},
        '{16'h1200, 16'h0, 1'h1, 1'h0, 2'h0, 4'h4, 2'h2, 2'h0},
        '{16'h0, 16'h1d00, 1'h0, 1'h1, 2'h3, 4'h2, 2'h0, 2'h1},
        '{16'h0, 16'h0018, 1'h0, 1'h0, 2'h2, 4'h1, 2'h0, 2'h2},
        '{16'h0007, 16'h0, 1'h1, 1'h1, 2'h1, 4'h8, 2'h0, 2'h0},
        '{16'h0017, 16'h0, 1'h1, 1'h1, 2'h1, 4'h7, 2'h0, 2'h0},
        '{16'h1200, 16'h0, 1'h1, 1'h0, 2'h1, 4'h4, 2'h0, 2'h0},
        '{16'h0, 16'h1d00, 1'h0, 1'h0, 2'h3, 4'h2, 2'h0, 2'h0},
        '{16'h1217, 16'h1d18, 1'h1, 1'h1, 2'h1, 4'h8, 2'h1, 2'h0}};
    mbi_far far (.clk(clk), .pci_ctl_wr, .pci_ctl_wdata, .addon_ctl_wr, .addon_ctl_wdata,
        .pci_mb_wr, .pci_mb_rd, .pci_mb_idx, .pci_mb_be, .addon_mb_wr, .addon_mb_rd,
        .addon_mb_idx, .addon_mb_be);
    mbi_top dut (.clk(clk), .resetn(resetn), .pci_ctl_wr, .pci_ctl_wdata, .pci_ctl_rdata,
        .addon_ctl_wr, .addon_ctl_wdata, .addon_ctl_rdata, .pci_mb_wr, .pci_mb_rd,
        .pci_mb_idx, .pci_mb_be, .addon_mb_wr, .addon_mb_rd, .addon_mb_idx, .addon_mb_be,
        .inta_n, .addon_irq_n);
    // ====
    // Clock and hang limit
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            end_of_test();
        end
    end
    // Verdict
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // ====
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        `CHK("pci_ctl_rdata", 32'h0, pci_ctl_rdata)
        `CHK("lines", 2'h3, {inta_n, addon_irq_n})
        resetn = 1'h1;
        foreach (rows[k]) begin
            far.reg_wr(1'h0, {16'h0, rows[k].pc});
            far.reg_wr(1'h1, {16'h0, rows[k].ac});
            `CHK("pci_cfg", rows[k].pc, pci_ctl_rdata[15:0])
            `CHK("addon_cfg", rows[k].ac, addon_ctl_rdata[15:0])
            far.acc(rows[k].s, rows[k].r, rows[k].i, rows[k].b);
            `CHK("pci_pend", rows[k].pp, pci_ctl_rdata[17:16])
            `CHK("addon_pend", rows[k].ap, addon_ctl_rdata[17:16])
            `CHK("inta_n", ~|rows[k].pp, inta_n)
            `CHK("addon_irq_n", ~|rows[k].ap, addon_irq_n)
            far.reg_wr(1'h0, {16'h3, rows[k].pc});
            far.reg_wr(1'h1, {16'h3, rows[k].ac});
            `CHK("lines", 2'h3, {inta_n, addon_irq_n})
        end
        // Only configuration bits are stored
        far.reg_wr(1'h0, 32'hffff_ffff);
        `CHK("pci_ctl_rdata", 32'h0000_1f1f, pci_ctl_rdata)
        // Event and clear on one edge: the event wins
        fork
            far.reg_wr(1'h0, 32'h0001_1f1f);
            far.acc(1'h1, 1'h1, 2'h3, 4'h8);
        join
        `CHK("inta_n", 1'h0, inta_n)
        // Enable off drops the line but keeps the flag
        far.reg_wr(1'h0, 32'h0000_1f0f);
        `CHK("pci_ctl_rdata", 32'h0001_1f0f, pci_ctl_rdata)
        `CHK("inta_n", 1'h1, inta_n)
        // Reset in mid-run
        resetn = 1'h0;
        @(negedge clk);
        resetn = 1'h1;
        `CHK("pci_ctl_rdata", 32'h0, pci_ctl_rdata)
        `CHK("lines", 2'h3, {inta_n, addon_irq_n})
        // First event after the mid-run reset is taken
        far.reg_wr(1'h1, 32'h0000_0010);
        far.acc(1'h0, 1'h0, 2'h0, 4'h1);
        `CHK("addon_ctl_rdata", 32'h0002_0010, addon_ctl_rdata)
        `CHK("addon_irq_n", 1'h0, addon_irq_n)
        end_of_test();
    end
endmodule : testbench
